// *** rtl/asrs_pkg.sv ***
// Constants and types for the asynchronous serial receive and status block
package asrs_pkg;
  // Register offsets; the channel index is added to each
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h02;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_TDR    = 8'h06;
  localparam logic [7:0] OFS_RXDATA = 8'h08;
  // Control A fields
  localparam int CA_WAKE    = 7;
  localparam int CA_RX_EN   = 6;
  localparam int CA_TX_EN   = 5;
  localparam int CA_ERR_CLR = 3;
  localparam int CA_PAR_EN  = 2;
  localparam int CA_DATA8   = 1;
  // Control B fields
  localparam int CB_MULTI_FMT = 6;
  localparam int CB_PAR_ODD = 4;
  localparam int CB_DCD_AUTO = 0;
  // Status fields
  localparam int ST_AVAIL    = 7;
  localparam int ST_OVERRUN  = 6;
  localparam int ST_PARERR   = 5;
  localparam int ST_FRMERR   = 4;
  localparam int ST_IRQEN    = 3;
  localparam int ST_BRK   = 2;
  localparam int ST_TDE   = 1;
  // Status FIFO entry fields, above the data byte
  localparam int SF_PARERR = 8;
  localparam int SF_FRMERR = 9;
  localparam int SF_BRK = 10;
  localparam int ENTRY_W = 11;
  // Depths, counts and reset values
  localparam int RX_FIFO_DEPTH = 4;
  localparam int BIT_CYCLES    = 16;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] TDR_RST    = 8'h00;
  // DMA routing codes that claim the receiver
  localparam logic [1:0] DMA_SRC_IO = 2'h3;
  localparam logic [1:0] DMA_ROUTE_RX = 2'h2;
  // Receiver states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_START = 6'h02,
    ST_DATA  = 6'h04,
    ST_PAR   = 6'h08,
    ST_WAKE  = 6'h10,
    ST_STOP  = 6'h20
  } asrs_state_t;
endpackage

// *** rtl/asrs_fifo_if.sv ***
// Push and pop handshake between receiver and its character FIFO
`timescale 1ns/10ps
interface asrs_fifo_if #(parameter int WIDTH = 11, parameter int DEPTH = 4);
  logic                       in_valid;
  logic                       in_ready;
  logic [WIDTH-1:0]           in_data;
  logic                       out_valid;
  logic                       out_ready;
  logic [WIDTH-1:0]           out_data;
  logic                       flush;
  logic [$clog2(DEPTH+1)-1:0] level;
  modport fifo (input in_valid, in_data, out_ready, flush,
                output in_ready, out_valid, out_data, level);
  modport user (output in_valid, in_data, out_ready, flush,
                input in_ready, out_valid, out_data, level);
endinterface

// *** rtl/asrs_fifo.sv ***
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/10ps
module asrs_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Handshake sides
  asrs_fifo_if.fifo port_if
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    rd_ptr;
  logic [PW-1:0]    wr_ptr;
  logic [CW-1:0]    cnt;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW-1:0]    next_wr_ptr;
  logic [CW-1:0]    next_cnt;
  logic             do_push;
  logic             do_pop;

  // Honest full and empty
  assign port_if.in_ready  = (cnt != CW'(DEPTH));
  assign port_if.out_valid = (cnt != '0);
  assign port_if.out_data  = mem[rd_ptr];
  assign port_if.level     = cnt;
  assign do_push = port_if.in_valid & port_if.in_ready;
  assign do_pop  = port_if.out_valid & port_if.out_ready;

  // Pointer and count update
  always_comb begin
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_cnt    = cnt;
    if (port_if.flush) begin
      next_rd_ptr = '0;
      next_wr_ptr = '0;
      next_cnt    = '0;
    end else begin
      if (do_push) begin
        next_wr_ptr = (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        next_rd_ptr = (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      next_cnt = cnt + CW'(do_push) - CW'(do_pop);
    end
  end

  // Pointer registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      cnt    <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      cnt    <= next_cnt;
    end
  end

  // Storage
  always_ff @(posedge core_clk) begin
    if (do_push && !port_if.flush) begin
      mem[wr_ptr] <= port_if.in_data;
    end
  end
endmodule

// *** rtl/asrs_rx.sv ***
// Serial receive channel with character and status FIFO and register port
`timescale 1ns/10ps
module asrs_rx #(
  parameter int         BIT_CYCLES = asrs_pkg::BIT_CYCLES,
  parameter int         DEPTH      = asrs_pkg::RX_FIFO_DEPTH,
  parameter logic [7:0] CH_INDEX   = 8'h00
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // I/O register port
  input  wire logic [7:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // Serial line and modem pins
  input  wire logic       serial_rx_input,
  input  wire logic       carrier_detect_ch0_n,
  // System state
  input  wire logic       io_halt_mode,
  // DMA routing
  input  wire logic [1:0] dma_source_mode,
  input  wire logic [1:0] dma_source_route,
  input  wire logic       dma1_io_direction,
  input  wire logic [1:0] dma1_io_route,
  // Transmitter side
  output logic      [7:0] tx_data,
  output logic            tx_data_valid,
  input  wire logic       tx_data_taken,
  output logic            tx_enable,
  output logic            tx_abort,
  // Interrupt request
  output logic            rx_irq_req
);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs + CH_INDEX);
  endfunction

  asrs_fifo_if #(.WIDTH(asrs_pkg::ENTRY_W), .DEPTH(DEPTH)) fq ();

  asrs_fifo #(
    .WIDTH (asrs_pkg::ENTRY_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .port_if  (fq.fifo)
  );

  // Pin synchronisers
  logic rx_s1;
  logic rx_s2;
  logic rx_d;
  logic dcd_s1;
  logic dcd_s2;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_s1  <= 1'b1;
      rx_s2  <= 1'b1;
      rx_d   <= 1'b1;
      dcd_s1 <= 1'b0;
      dcd_s2 <= 1'b0;
    end else begin
      rx_s1  <= serial_rx_input;
      rx_s2  <= rx_s1;
      rx_d   <= rx_s2;
      dcd_s1 <= carrier_detect_ch0_n;
      dcd_s2 <= dcd_s1;
    end
  end

  // Register state
  logic [7:0] control_a_reg;
  logic [7:0] control_b_reg;
  logic [7:0] tdr;
  logic       rx_irq_enable;
  logic       tx_data_empty;
  logic       overrun_flag;
  logic       parity_error_flag;
  logic       framing_error_flag;
  logic       break_flag;
  logic       ovr_pending;
  logic [CW-1:0] ovr_count;
  logic       head_new;
  logic [7:0] next_control_a_reg;
  logic [7:0] next_control_b_reg;
  logic [7:0] next_tdr;
  logic       next_rx_irq_enable;
  logic       next_tx_data_empty;
  logic       next_overrun_flag;
  logic       next_parity_error_flag;
  logic       next_framing_error_flag;
  logic       next_break_flag;
  logic       next_ovr_pending;
  logic [CW-1:0] next_ovr_count;
  logic       next_head_new;
  logic       next_tx_abort;
  logic [7:0] next_io_rdata;

  // Decoded controls
  logic multiproc_wake_enable;
  logic rx_enable;
  logic parity_check_enable;
  logic data8;
  logic multiproc_format_select;
  logic parity_odd_select;
  logic carrier_lost;
  logic flush;
  logic error_flag_clear;
  logic rd_pop;
  logic rx_data_available;
  logic dma_claims_rx;
  assign multiproc_wake_enable   = control_a_reg[asrs_pkg::CA_WAKE];
  assign rx_enable               = control_a_reg[asrs_pkg::CA_RX_EN];
  assign tx_enable               = control_a_reg[asrs_pkg::CA_TX_EN];
  assign parity_check_enable     = control_a_reg[asrs_pkg::CA_PAR_EN];
  assign data8                   = control_a_reg[asrs_pkg::CA_DATA8];
  assign multiproc_format_select = control_b_reg[asrs_pkg::CB_MULTI_FMT];
  assign parity_odd_select       = control_b_reg[asrs_pkg::CB_PAR_ODD];
  assign carrier_lost = (CH_INDEX == 8'h00) && control_b_reg[asrs_pkg::CB_DCD_AUTO]
                        && dcd_s2;
  // Halt mode and lost carrier empty the FIFO and drop all error flags
  assign flush = io_halt_mode | carrier_lost;
  assign error_flag_clear = io_wr && hit(io_addr, asrs_pkg::OFS_CTRL_A)
                            && io_wdata[asrs_pkg::CA_ERR_CLR];
  assign rd_pop = io_rd && hit(io_addr, asrs_pkg::OFS_RXDATA);
  // One pop removes data and status together
  assign fq.out_ready = rd_pop;
  assign fq.flush = flush;
  // Data available follows a non-empty FIFO
  assign rx_data_available = fq.out_valid;
  assign dma_claims_rx = ((dma_source_mode == asrs_pkg::DMA_SRC_IO)
                          && (dma_source_route == asrs_pkg::DMA_ROUTE_RX))
                         || (dma1_io_direction
                          && (dma1_io_route == asrs_pkg::DMA_ROUTE_RX));
  // Interrupt request
  assign rx_irq_req = rx_irq_enable && ((rx_data_available && !dma_claims_rx)
                      || overrun_flag || parity_error_flag || framing_error_flag);

  // Receiver state
  asrs_pkg::asrs_state_t state;
  asrs_pkg::asrs_state_t next_state;
  logic [15:0] baud_cnt;
  logic [15:0] next_baud_cnt;
  logic [2:0]  bit_cnt;
  logic [2:0]  next_bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic        par_bit;
  logic        next_par_bit;
  logic        wake_bit;
  logic        next_wake_bit;
  logic        char_done;
  logic        stop_ok;
  logic [7:0]  rx_char;
  logic        par_err;
  logic        accept;

  // Bit sampling and frame sequencing
  always_comb begin
    next_state    = state;
    next_baud_cnt = baud_cnt;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_par_bit  = par_bit;
    next_wake_bit = wake_bit;
    char_done     = 1'b0;
    stop_ok       = 1'b1;
    if (baud_cnt != 16'h0000) begin
      next_baud_cnt = baud_cnt - 16'h0001;
    end
    case (state)
      asrs_pkg::ST_IDLE: begin
        if (rx_enable && rx_d && !rx_s2) begin
          next_state    = asrs_pkg::ST_START;
          next_baud_cnt = BIT_HALF;
        end
      end
      asrs_pkg::ST_START: begin
        if (baud_cnt == 16'h0000) begin
          next_state    = rx_s2 ? asrs_pkg::ST_IDLE : asrs_pkg::ST_DATA;
          next_baud_cnt = BIT_LAST;
          next_bit_cnt  = 3'h0;
        end
      end
      asrs_pkg::ST_DATA: begin
        if (baud_cnt == 16'h0000) begin
          next_shift    = {rx_s2, shift[7:1]};
          next_baud_cnt = BIT_LAST;
          next_bit_cnt  = bit_cnt + 3'h1;
          if (bit_cnt == (data8 ? 3'h7 : 3'h6)) begin
            next_state = parity_check_enable ? asrs_pkg::ST_PAR
                       : (multiproc_format_select ? asrs_pkg::ST_WAKE : asrs_pkg::ST_STOP);
          end
        end
      end
      asrs_pkg::ST_PAR: begin
        if (baud_cnt == 16'h0000) begin
          next_par_bit  = rx_s2;
          next_baud_cnt = BIT_LAST;
          next_state    = multiproc_format_select ? asrs_pkg::ST_WAKE : asrs_pkg::ST_STOP;
        end
      end
      asrs_pkg::ST_WAKE: begin
        if (baud_cnt == 16'h0000) begin
          next_wake_bit = rx_s2;
          next_baud_cnt = BIT_LAST;
          next_state    = asrs_pkg::ST_STOP;
        end
      end
      asrs_pkg::ST_STOP: begin
        if (baud_cnt == 16'h0000) begin
          char_done  = 1'b1;
          stop_ok    = rx_s2;
          next_state = asrs_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = asrs_pkg::ST_IDLE;
      end
    endcase
    if (!rx_enable) begin
      next_state = asrs_pkg::ST_IDLE;
    end
  end

  // Receiver registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state    <= asrs_pkg::ST_IDLE;
      baud_cnt <= 16'h0000;
      bit_cnt  <= 3'h0;
      shift    <= 8'h00;
      par_bit  <= 1'b0;
      wake_bit <= 1'b0;
    end else begin
      state    <= next_state;
      baud_cnt <= next_baud_cnt;
      bit_cnt  <= next_bit_cnt;
      shift    <= next_shift;
      par_bit  <= next_par_bit;
      wake_bit <= next_wake_bit;
    end
  end

  // Finished character and its status entry
  assign rx_char = data8 ? shift : {1'b0, shift[7:1]};
  assign par_err = parity_check_enable && ((^rx_char ^ par_bit) != parity_odd_select);
  assign accept  = !(multiproc_format_select && multiproc_wake_enable && !wake_bit);
  // Errored characters still load; overrun drops until the flag sets
  assign fq.in_valid = char_done && accept && !ovr_pending && !flush;
  assign fq.in_data  = {(rx_char == 8'h00) && !stop_ok && !par_bit,
                        !stop_ok, par_err, rx_char};

  // Register file and flag updates
  always_comb begin
    next_control_a_reg      = control_a_reg;
    next_control_b_reg      = control_b_reg;
    next_tdr                = tdr;
    next_rx_irq_enable      = rx_irq_enable;
    next_tx_data_empty      = tx_data_empty;
    next_overrun_flag       = overrun_flag;
    next_parity_error_flag  = parity_error_flag;
    next_framing_error_flag = framing_error_flag;
    next_break_flag         = break_flag;
    next_ovr_pending        = ovr_pending;
    next_ovr_count          = ovr_count;
    next_io_rdata           = io_rdata;
    next_tx_abort           = 1'b0;
    // Head changes on a push into empty or a pop that leaves a char behind
    next_head_new = !flush && ((fq.in_valid && !fq.out_valid)
                    || (rd_pop && ((fq.level > CW'(1)) || fq.in_valid)));
    if (io_wr) begin
      if (hit(io_addr, asrs_pkg::OFS_CTRL_A)) begin
        next_control_a_reg = io_wdata & ~(8'h01 << asrs_pkg::CA_ERR_CLR);
        // Dropping transmit enable aborts; the empty flag is untouched
        next_tx_abort = tx_enable && !io_wdata[asrs_pkg::CA_TX_EN];
      end
      if (hit(io_addr, asrs_pkg::OFS_CTRL_B)) begin
        next_control_b_reg = io_wdata;
      end
      if (hit(io_addr, asrs_pkg::OFS_STAT)) begin
        next_rx_irq_enable = io_wdata[asrs_pkg::ST_IRQEN];
      end
      if (hit(io_addr, asrs_pkg::OFS_TDR)) begin
        next_tdr           = io_wdata;
        next_tx_data_empty = 1'b0;
      end
    end
    if (tx_data_taken && tx_data_valid) begin
      next_tx_data_empty = 1'b1;
    end
    // Error clears, then sets; a same-cycle head change ORs its entry onto the old flags, undoing the clear
    if (error_flag_clear || flush) begin
      next_overrun_flag       = 1'b0;
      next_parity_error_flag  = 1'b0;
      next_framing_error_flag = 1'b0;
      next_break_flag         = 1'b0;
    end
    if (head_new && fq.out_valid && !flush) begin
      next_parity_error_flag  = parity_error_flag | fq.out_data[asrs_pkg::SF_PARERR];
      next_framing_error_flag = framing_error_flag | fq.out_data[asrs_pkg::SF_FRMERR];
      next_break_flag         = break_flag | fq.out_data[asrs_pkg::SF_BRK];
    end
    // Overrun: remember how many chars stand ahead of the lost one
    if (flush) begin
      next_ovr_pending = 1'b0;
    end else if (ovr_pending) begin
      if (ovr_count <= CW'(1)) begin
        next_overrun_flag = 1'b1;
        next_ovr_pending  = 1'b0;
      end else if (rd_pop) begin
        next_ovr_count = ovr_count - CW'(1);
      end
    end else if (char_done && accept && !fq.in_ready) begin
      next_ovr_pending = 1'b1;
      next_ovr_count   = fq.level - CW'(rd_pop);
    end
    if (flush) begin
      next_control_a_reg[asrs_pkg::CA_RX_EN] = 1'b0;
      next_control_a_reg[asrs_pkg::CA_TX_EN] = 1'b0;
      next_tx_abort = tx_enable;
    end
    // Read data; a transmit data read changes nothing else
    if (io_rd) begin
      next_io_rdata = 8'h00;
      if (hit(io_addr, asrs_pkg::OFS_CTRL_A)) begin
        next_io_rdata = control_a_reg;
      end
      if (hit(io_addr, asrs_pkg::OFS_CTRL_B)) begin
        next_io_rdata = control_b_reg;
      end
      if (hit(io_addr, asrs_pkg::OFS_TDR)) begin
        next_io_rdata = tdr;
      end
      if (hit(io_addr, asrs_pkg::OFS_RXDATA)) begin
        next_io_rdata = fq.out_valid ? fq.out_data[7:0] : 8'h00;
      end
      if (hit(io_addr, asrs_pkg::OFS_STAT)) begin
        next_io_rdata[asrs_pkg::ST_AVAIL]   = rx_data_available;
        next_io_rdata[asrs_pkg::ST_OVERRUN] = overrun_flag;
        next_io_rdata[asrs_pkg::ST_PARERR]  = parity_error_flag;
        next_io_rdata[asrs_pkg::ST_FRMERR]  = framing_error_flag;
        next_io_rdata[asrs_pkg::ST_IRQEN]   = rx_irq_enable;
        next_io_rdata[asrs_pkg::ST_BRK]  = break_flag;
        next_io_rdata[asrs_pkg::ST_TDE]  = tx_data_empty;
      end
    end
  end

  // Register file flops; reset clears wake enable and all error flags, and sets transmit data empty
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      control_a_reg      <= asrs_pkg::CTRL_A_RST;
      control_b_reg      <= asrs_pkg::CTRL_B_RST;
      tdr                <= asrs_pkg::TDR_RST;
      rx_irq_enable      <= 1'b0;
      tx_data_empty      <= 1'b1;
      overrun_flag       <= 1'b0;
      parity_error_flag  <= 1'b0;
      framing_error_flag <= 1'b0;
      break_flag         <= 1'b0;
      ovr_pending        <= 1'b0;
      ovr_count          <= '0;
      head_new           <= 1'b0;
      tx_abort           <= 1'b0;
      io_rdata           <= 8'h00;
    end else begin
      control_a_reg      <= next_control_a_reg;
      control_b_reg      <= next_control_b_reg;
      tdr                <= next_tdr;
      rx_irq_enable      <= next_rx_irq_enable;
      tx_data_empty      <= next_tx_data_empty;
      overrun_flag       <= next_overrun_flag;
      parity_error_flag  <= next_parity_error_flag;
      framing_error_flag <= next_framing_error_flag;
      break_flag         <= next_break_flag;
      ovr_pending        <= next_ovr_pending;
      ovr_count          <= next_ovr_count;
      head_new           <= next_head_new;
      tx_abort           <= next_tx_abort;
      io_rdata           <= next_io_rdata;
    end
  end

  // Transmit handoff
  assign tx_data       = tdr;
  assign tx_data_valid = tx_enable && !tx_data_empty;
endmodule

// *** tb/asrs_line_model.sv ***
// Remote serial transmitter driving the receive line
`timescale 1ns/10ps
module asrs_line_model #(
  parameter int BC = 4
) (
  // Clock and line
  input wire logic core_clk,
  output logic     line
);
  // Line idles high outside frames
  initial begin
    line = 1'b1;
  end
  // Start, data LSB first, optional parity and wake bit, stop, idle
  task automatic send(input logic [7:0] c, input int p, input int w, input logic s);
    logic q[$];
    q = {1'b0};
    for (int i = 0; i < 8; i++) begin
      q.push_back(c[i]);
    end
    if (p >= 0) begin
      q.push_back(p[0]);
    end
    if (w >= 0) begin
      q.push_back(w[0]);
    end
    q.push_back(s);
    q.push_back(1'b1);
    foreach (q[i]) begin
      @(posedge core_clk);
      line <= q[i];
      repeat (BC - 1) @(posedge core_clk);
    end
  endtask
endmodule

// *** tb/asrs_rx_asserts.sv ***
// Port checks for the serial receive channel
`timescale 1ns/10ps
module asrs_rx_asserts #(
  parameter int         BIT_CYCLES = 16,
  parameter int         DEPTH      = 4,
  parameter logic [7:0] CH_INDEX   = 8'h00
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] io_addr,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Line and system
  input wire logic       serial_rx_input,
  input wire logic       carrier_detect_ch0_n,
  input wire logic       io_halt_mode,
  // DMA routing
  input wire logic [1:0] dma_source_mode,
  input wire logic [1:0] dma_source_route,
  input wire logic       dma1_io_direction,
  input wire logic [1:0] dma1_io_route,
  // Transmitter and interrupt
  input wire logic [7:0] tx_data,
  input wire logic       tx_data_valid,
  input wire logic       tx_data_taken,
  input wire logic       tx_enable,
  input wire logic       tx_abort,
  input wire logic       rx_irq_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] ofs;
  logic       mapped, claim, st_rd;
  // Address decode, DMA claim, clean status read
  assign ofs    = io_addr - CH_INDEX;
  assign mapped = ofs inside {8'h00, 8'h02, 8'h04, 8'h06, 8'h08};
  assign claim  = (dma_source_mode == 2'h3 && dma_source_route == 2'h2)
                  || (dma1_io_direction && dma1_io_route == 2'h2);
  assign st_rd  = io_rd && !io_wr && !io_halt_mode && !carrier_detect_ch0_n && ofs == 8'h04;
  // Assertions
  a_reset_quiet: assert property ($rose(rst_n) |-> io_rdata == 8'h00 && !rx_irq_req && !tx_enable)
    else $error("outputs not quiet after reset");
  a_unmapped_zero: assert property (io_rd && !mapped |=> io_rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved without a read");
  a_tdr_read_clean: assert property (io_rd && !io_wr && ofs == 8'h06 |=> $stable(tx_data))
    else $error("transmit data changed by read");
  a_abort_on_off: assert property ($fell(tx_enable) |-> ##[0:1] tx_abort)
    else $error("no abort after transmit disable");
  a_abort_single: assert property (tx_abort |=> !tx_abort && !tx_enable)
    else $error("abort pulse too long");
  a_halt_quiet: assert property (io_halt_mode |=> !rx_irq_req && !tx_enable)
    else $error("halt left request or enable");
  a_irq_data: assert property (st_rd ##1 (io_rdata[7] && io_rdata[3] && !claim) |-> rx_irq_req)
    else $error("no request for data available");
  a_irq_error: assert property (st_rd ##1 (io_rdata[3] && io_rdata[6:4] != 3'h0) |-> rx_irq_req)
    else $error("no request for error flag");
  // Main scenarios
  c_overrun: cover property (st_rd ##1 io_rdata[6]);
  c_abort: cover property ($fell(tx_enable));
  c_irq_drop: cover property (rx_irq_req ##1 !rx_irq_req);
endmodule
bind asrs_rx asrs_rx_asserts #(.BIT_CYCLES(BIT_CYCLES), .DEPTH(DEPTH), .CH_INDEX(CH_INDEX))
  i_asrs_rx_asserts (.core_clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
  .serial_rx_input, .carrier_detect_ch0_n, .io_halt_mode, .dma_source_mode,
  .dma_source_route, .dma1_io_direction, .dma1_io_route, .tx_data, .tx_data_valid,
  .tx_data_taken, .tx_enable, .tx_abort, .rx_irq_req);

// *** tb/asrs_rx_tb.sv ***
// Self-checking bench for the serial receive channel
`timescale 1ns/10ps
module asrs_rx_tb;
  localparam int BC = 4;
  typedef struct packed {
    logic [7:0] v;
    logic [7:0] m;
  } asrs_note_t;
  logic       core_clk, rst_n, io_wr, io_rd, rd_d, io_halt_mode, line, dma1_io_direction;
  logic       tx_data_valid, tx_enable, tx_abort, rx_irq_req, dcd_n;
  logic [7:0] io_addr, io_wdata, io_rdata, tx_data;
  logic [1:0] dma_source_mode, dma_source_route, dma1_io_route;
  logic [7:0] d[6];
  asrs_note_t notes[$];
  asrs_note_t nt;
  int         miscompares, cmp_count;
  // Design and line partner
  asrs_rx #(.BIT_CYCLES(BC)) i_asrs_rx (.core_clk, .rst_n, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .serial_rx_input(line), .carrier_detect_ch0_n(dcd_n),
    .io_halt_mode, .dma_source_mode, .dma_source_route, .dma1_io_direction,
    .dma1_io_route, .tx_data, .tx_data_valid, .tx_data_taken(1'b0), .tx_enable,
    .tx_abort, .rx_irq_req);
  asrs_line_model #(.BC(BC)) i_asrs_line_model (.core_clk, .line);
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Compare and report
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (e !== s) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    io_addr  <= a;
    io_wdata <= v;
    io_wr    <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
    idle(2);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge core_clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    notes.push_back('{e & m, m});
    @(posedge core_clk);
    io_rd <= 1'b0;
    idle(3);
  endtask
  task automatic send(input logic [7:0] c, input int p, input int w, input logic s);
    i_asrs_line_model.send(c, p, w, s);
    idle(4);
  endtask
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask
  // Read monitor takes the oldest note
  always @(posedge core_clk) begin
    rd_d <= io_rd;
    if (rd_d === 1'b1) begin
      nt = notes.pop_front();
      chk("io_rdata", nt.v, io_rdata & nt.m);
    end
  end
  // Watchdog
  initial begin
    idle(50000);
    miscompares++;
    end_sim();
  end
  // Main sequence
  initial begin
    {rst_n, io_wr, io_rd, dcd_n, io_halt_mode, dma1_io_direction} = '0;
    {io_addr, io_wdata, dma_source_mode, dma_source_route, dma1_io_route} = '0;
    miscompares = 0;
    cmp_count = 0;
    void'($urandom(32'h9580));
    foreach (d[i]) d[i] = 8'($urandom);
    idle(6);
    rst_n <= 1'b1;
    rd(8'h04, 8'h00, 8'hF8);
    rd(8'h1F, 8'h00, 8'hFF);
    done("reset");
    wr(8'h00, 8'h62);
    wr(8'h06, d[5]);
    rd(8'h06, d[5], 8'hFF);
    chk("tx_data", d[5], tx_data);
    chk("tx_data_valid", 8'h01, {7'h00, tx_data_valid});
    wr(8'h00, 8'h42);
    chk("tx_enable", 8'h00, {7'h00, tx_enable});
    rd(8'h04, 8'h00, 8'h02);
    done("transmit register");
    for (int i = 0; i < 6; i++) send(d[i], -1, -1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(8'h08, d[i], 8'hFF);
      if (i < 3) rd(8'h04, (i == 2) ? 8'h40 : 8'h00, 8'h40);
    end
    rd(8'h04, 8'h40, 8'hC0);
    wr(8'h00, 8'h4A);
    rd(8'h04, 8'h00, 8'h70);
    done("overrun");
    wr(8'h00, 8'h46);
    send(d[0], ^d[0], -1, 1'b1);
    send(d[1], ~^d[1], -1, 1'b1);
    send(d[2], ^d[2], -1, 1'b0);
    rd(8'h04, 8'h80, 8'hB0);
    rd(8'h08, d[0], 8'hFF);
    rd(8'h04, 8'hA0, 8'hB0);
    rd(8'h08, d[1], 8'hFF);
    rd(8'h04, 8'hB0, 8'hB0);
    rd(8'h08, d[2], 8'hFF);
    wr(8'h04, 8'h08);
    rd(8'h04, 8'h38, 8'h38);
    chk("rx_irq_req", 8'h01, {7'h00, rx_irq_req});
    wr(8'h00, 8'h4A);
    chk("rx_irq_req", 8'h00, {7'h00, rx_irq_req});
    done("errors");
    for (int k = 0; k < 3; k++) begin
      dma_source_mode   <= (k == 1) ? 2'h3 : 2'($urandom_range(2));
      dma_source_route  <= 2'h2;
      dma1_io_direction <= (k == 2);
      dma1_io_route     <= (k == 2) ? 2'h2 : 2'h1;
      send(d[3 + k], -1, -1, 1'b1);
      rd(8'h04, 8'h88, 8'h88);
      chk("rx_irq_req", 8'(k == 0), {7'h00, rx_irq_req});
      rd(8'h08, d[3 + k], 8'hFF);
      chk("rx_irq_req", 8'h00, {7'h00, rx_irq_req});
    end
    done("interrupt");
    wr(8'h02, 8'h40);
    wr(8'h00, 8'hC2);
    send(d[0], -1, 0, 1'b1);
    rd(8'h04, 8'h00, 8'h80);
    send(d[1], -1, 1, 1'b1);
    rd(8'h08, d[1], 8'hFF);
    done("wake");
    send(d[2], -1, 1, 1'b1);
    rd(8'h04, 8'h80, 8'h80);
    io_halt_mode <= 1'b1;
    idle(2);
    io_halt_mode <= 1'b0;
    wr(8'h08, 8'h55);
    rd(8'h04, 8'h00, 8'hF0);
    done("halt");
    wr(8'h02, 8'h01);
    wr(8'h00, 8'h4A);
    send(d[3], -1, -1, 1'b0);
    rd(8'h04, 8'h90, 8'h90);
    dcd_n <= 1'b1;
    idle(4);
    dcd_n <= 1'b0;
    rd(8'h04, 8'h00, 8'hF0);
    done("carrier");
    end_sim();
  end
endmodule
